// ---- rtl/bbc_pkg.sv ----
// Shared constants for the branch, bit and control instruction decode block.
// Assumes an 8-bit opcode stream and a 256-byte data space behind a simple port.
package bbc_pkg;
	localparam int PC_W = 12;
	localparam int BYTE_W = 8;
	// Opcode field positions and patterns
	localparam logic [2:0] SHORT_NZ = 3'h0;
	localparam logic [2:0] SHORT_NC = 3'h2;
	localparam logic [2:0] SHORT_Z = 3'h4;
	localparam logic [2:0] SHORT_C = 3'h6;
	localparam logic [3:0] LOW_BITTEST = 4'h3;
	localparam logic [3:0] LOW_EXT_CALL = 4'h1;
	localparam logic [3:0] LOW_EXT_JUMP = 4'h9;
	localparam logic [3:0] LOW_BITDIR = 4'hB;
	localparam int TEST_SEL_BIT = 4;
	localparam int BITDIR_SET_BIT = 4;
	localparam logic [7:0] OP_SUB_RETURN = 8'hCD;
	localparam logic [7:0] OP_INT_RETURN = 8'h4D;
	localparam logic [7:0] OP_STOP = 8'h6D;
	localparam logic [7:0] OP_WAIT = 8'hED;
	localparam logic [7:0] OP_NOP = 8'h04;
	// Cycle counts per instruction class
	localparam logic [2:0] CYC_SHORT = 3'h2;
	localparam logic [2:0] CYC_BITTEST = 3'h5;
	localparam logic [2:0] CYC_BITDIR = 3'h4;
	localparam logic [2:0] CYC_CTRL = 3'h2;
	localparam logic [2:0] CYC_EXT = 3'h4;
	// Byte lengths
	localparam logic [PC_W-1:0] LEN_1 = 12'h001;
	localparam logic [PC_W-1:0] LEN_2 = 12'h002;
	localparam logic [PC_W-1:0] LEN_3 = 12'h003;
	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam logic [2:0] CNT_ZERO = 3'h0;
	typedef enum logic [5:0] {
		BBC_FETCH = 6'h01,
		BBC_OPND1 = 6'h02,
		BBC_OPND2 = 6'h04,
		BBC_RDATA = 6'h08,
		BBC_WDATA = 6'h10,
		BBC_FINISH = 6'h20
	} bbc_state_t;
	typedef enum logic [6:0] {
		BBC_K_SHORT = 7'h01,
		BBC_K_BITTEST = 7'h02,
		BBC_K_BITDIR = 7'h04,
		BBC_K_JUMP = 7'h08,
		BBC_K_CALL = 7'h10,
		BBC_K_CTRL = 7'h20,
		BBC_K_OTHER = 7'h40
	} bbc_kind_t;
endpackage

// ---- rtl/bbc_stack.sv ----
// Small return-address stack for the long call and return instructions.
// Assumes push and pop never coincide; overflow silently drops the oldest entry.
`timescale 1ns/1ns
`default_nettype none
module bbc_stack #(
	parameter int DEPTH = 6,
	parameter int WIDTH = 12
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] push_data,
	output logic [WIDTH-1:0] top_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] top;
	} bbc_stk_t;
	bbc_stk_t st;
	bbc_stk_t next_st;
	// Shift register stack; the top entry is also held in a read register
	always_comb begin
		next_st = st;
		if (push) begin
			for (int i = DEPTH-1; i > 0; i--) begin
				next_st.mem[i] = st.mem[i-1];
			end
			next_st.mem[0] = push_data;
			next_st.top = push_data;
		end else if (pop) begin
			for (int i = 0; i < DEPTH-1; i++) begin
				next_st.mem[i] = st.mem[i+1];
			end
			next_st.mem[DEPTH-1] = '0;
			next_st.top = st.mem[1];
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign top_data = st.top;
endmodule // bbc_stack
`default_nettype wire

// ---- rtl/bbc_core.sv ----
// Decode and execute of short branches, bit-test branches, bit set/clear,
// return, wait/stop and long jump/call.
// Assumes program memory and data space answer in the same cycle (combinational read).
`timescale 1ns/1ns
`default_nettype none
module bbc_core #(
	parameter int STACK_DEPTH = 6
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic watchdog_option,
	input wire logic wake_event,
	input wire logic [7:0] prog_data,
	output logic [11:0] prog_addr,
	input wire logic [7:0] data_rdata,
	output logic [7:0] data_addr,
	output logic [7:0] data_wdata,
	output logic data_we,
	output logic [11:0] pc,
	output logic flag_c,
	output logic flag_z,
	output logic wait_mode,
	output logic stop_mode,
	output logic illegal_op,
	output logic instr_done
);
	typedef struct packed {
		// Sequencer position and decoded class
		bbc_pkg::bbc_state_t state;
		bbc_pkg::bbc_kind_t kind;
		logic [11:0] pc;
		// Instruction bytes as they arrive
		logic [7:0] opcode;
		logic [7:0] opnd1;
		logic [7:0] rdata; // Data byte, later reused for the displacement
		logic [2:0] cnt;
		// Flags shared with the rest of the core
		logic c;
		logic z;
		// Low-power modes and status
		logic waiting;
		logic stopped;
		logic illegal;
		logic done;
		// Data-space write port and jump/call target
		logic [7:0] wdata;
		logic we;
		logic [11:0] target;
	} bbc_core_t;
	bbc_core_t s;
	bbc_core_t next_s;
	// Return stack handshake
	logic st_push;
	logic st_pop;
	logic [11:0] st_top;
	// Decoded operand fields
	logic [2:0] bit_num;
	logic short_take;
	logic test_bit;
	logic [11:0] short_disp;
	logic [11:0] long_disp;
	// Return addresses of long calls. Nesting deeper than the stack depth
	// silently loses the oldest entry; software must keep within it.
	bbc_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(bbc_pkg::PC_W)
	) u_stack (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.push(st_push),
		.pop(st_pop),
		.push_data(s.pc + bbc_pkg::LEN_2),
		.top_data(st_top)
	);
	// Opcode classes, by the low bits of the first byte:
	//   low bits 000, 010, 100, 110: short branch, except the no-op code
	//   low nibble 0011: bit-test branch, bit 4 picks the sense
	//   low nibble 1011: bit set or clear, bit 4 high sets
	//   low nibble 0001: long call; low nibble 1001: long jump
	//   a few fixed inherent codes: return, interrupt return, stop, wait, no-op
	// Anything else belongs to the load/store and arithmetic decoders beside
	// this block; here it only raises the foreign-opcode flag and steps over
	// one byte, so that a stand-alone run cannot lock up.
	// Operand field extraction
	always_comb begin
		// Bit-test keeps bit number reversed in bits 7..5; bit direct uses it the same way
		bit_num = {s.opcode[5], s.opcode[6], s.opcode[7]};
		test_bit = s.rdata[bit_num];
		// Five-bit signed field: 0 means +1, so the span is -15..+16
		short_disp = {{7{s.opcode[7]}}, s.opcode[7:3]} + bbc_pkg::LEN_1;
		// Eight-bit signed field counted from the third byte: span -126..+129
		long_disp = {{4{s.rdata[7]}}, s.rdata} + bbc_pkg::LEN_2;
		unique case (s.opcode[2:0])
			bbc_pkg::SHORT_NZ: short_take = !s.z;
			bbc_pkg::SHORT_NC: short_take = !s.c;
			bbc_pkg::SHORT_Z: short_take = s.z;
			bbc_pkg::SHORT_C: short_take = s.c;
			default: short_take = 1'b0;
		endcase
	end
	// Cycle walk per class, counted from the fetch cycle c0:
	//   short branch, return, wait, stop, no-op, foreign opcode:
	//     c0 fetch, c1 finish; pc and the done strobe move on the edge ending c1.
	//   long jump and call:
	//     c0 fetch, c1 second byte, c2 and c3 finish; a call pushes pc plus two.
	//   bit set and clear:
	//     c0 fetch, c1 address byte, c2 data read, c3 byte rebuilt;
	//     the write strobe and done leave together on the edge ending c3.
	//   bit-test branch:
	//     c0 fetch, c1 address byte, c2 data read, c3 displacement byte
	//     and carry capture, c4 finish.
	// The counter is loaded with the length less one at fetch and ticks down
	// every cycle; the finish state ends the instruction when it reads one.
	// The next fetch happens in the cycle in which done is high, so
	// instructions run back to back with no idle cycle between them.
	// Flag policy: carry changes only for bit-test branches, where it takes
	// the tested bit; zero is never written by any instruction of this block,
	// so the zero-conditioned branches see the value left there by reset
	// until the arithmetic decoders take over that flag.
	// Sequencer: fetch, operand bytes, data access, then hold until the cycle count ends
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.we = 1'b0;
		st_push = 1'b0;
		st_pop = 1'b0;
		prog_addr = s.pc;
		data_addr = s.opnd1;
		if (s.cnt != bbc_pkg::CNT_ZERO) begin
			next_s.cnt = s.cnt - bbc_pkg::CNT_ONE;
		end
		unique case (s.state)
			bbc_pkg::BBC_FETCH: begin
				if (s.waiting || s.stopped) begin
					// A wake edge only clears the mode; fetching resumes on the next edge
					if (wake_event) begin
						next_s.waiting = 1'b0;
						next_s.stopped = 1'b0;
					end
				end else begin
					next_s.opcode = prog_data;
					next_s.illegal = 1'b0;
					next_s.state = bbc_pkg::BBC_OPND1;
					if ((prog_data[2:0] == bbc_pkg::SHORT_NZ
							|| prog_data[2:0] == bbc_pkg::SHORT_NC
							|| prog_data[2:0] == bbc_pkg::SHORT_Z
							|| prog_data[2:0] == bbc_pkg::SHORT_C)
							&& prog_data != bbc_pkg::OP_NOP) begin
						// Short branch: all 32 displacement encodings per condition, bar the no-op code
						next_s.kind = bbc_pkg::BBC_K_SHORT;
						next_s.cnt = bbc_pkg::CYC_SHORT - bbc_pkg::CNT_ONE;
						next_s.state = bbc_pkg::BBC_FINISH;
					end else if (prog_data[3:0] == bbc_pkg::LOW_BITTEST) begin
						next_s.kind = bbc_pkg::BBC_K_BITTEST;
						next_s.cnt = bbc_pkg::CYC_BITTEST - bbc_pkg::CNT_ONE;
					end else if (prog_data[3:0] == bbc_pkg::LOW_BITDIR) begin
						next_s.kind = bbc_pkg::BBC_K_BITDIR;
						next_s.cnt = bbc_pkg::CYC_BITDIR - bbc_pkg::CNT_ONE;
					end else if (prog_data[3:0] == bbc_pkg::LOW_EXT_CALL) begin
						next_s.kind = bbc_pkg::BBC_K_CALL;
						next_s.cnt = bbc_pkg::CYC_EXT - bbc_pkg::CNT_ONE;
					end else if (prog_data[3:0] == bbc_pkg::LOW_EXT_JUMP) begin
						next_s.kind = bbc_pkg::BBC_K_JUMP;
						next_s.cnt = bbc_pkg::CYC_EXT - bbc_pkg::CNT_ONE;
					end else if (prog_data == bbc_pkg::OP_SUB_RETURN
							|| prog_data == bbc_pkg::OP_INT_RETURN
							|| prog_data == bbc_pkg::OP_STOP || prog_data == bbc_pkg::OP_WAIT
							|| prog_data == bbc_pkg::OP_NOP) begin
						next_s.kind = bbc_pkg::BBC_K_CTRL;
						next_s.cnt = bbc_pkg::CYC_CTRL - bbc_pkg::CNT_ONE;
						next_s.state = bbc_pkg::BBC_FINISH;
					end else begin
						// Other groups belong to other decoders; skip one byte
						next_s.kind = bbc_pkg::BBC_K_OTHER;
						next_s.illegal = 1'b1;
						next_s.cnt = bbc_pkg::CYC_CTRL - bbc_pkg::CNT_ONE;
						next_s.state = bbc_pkg::BBC_FINISH;
					end
				end
			end
			bbc_pkg::BBC_OPND1: begin
				// Second byte: data address or low target byte
				prog_addr = s.pc + bbc_pkg::LEN_1;
				next_s.opnd1 = prog_data;
				next_s.target = {s.opcode[7:4], prog_data};
				unique case (s.kind)
					bbc_pkg::BBC_K_BITTEST: next_s.state = bbc_pkg::BBC_RDATA;
					bbc_pkg::BBC_K_BITDIR: next_s.state = bbc_pkg::BBC_RDATA;
					default: next_s.state = bbc_pkg::BBC_FINISH;
				endcase
			end
			bbc_pkg::BBC_RDATA: begin
				// Data byte arrives in the same cycle as its address
				next_s.rdata = data_rdata;
				if (s.kind == bbc_pkg::BBC_K_BITTEST) begin
					next_s.state = bbc_pkg::BBC_OPND2;
				end else begin
					next_s.state = bbc_pkg::BBC_WDATA;
				end
			end
			bbc_pkg::BBC_OPND2: begin
				// Third byte: displacement replaces the sampled data, tested bit kept in carry
				prog_addr = s.pc + bbc_pkg::LEN_2;
				next_s.c = test_bit;
				next_s.rdata = prog_data;
				next_s.state = bbc_pkg::BBC_FINISH;
			end
			bbc_pkg::BBC_WDATA: begin
				// Read-modify-write of the whole byte; why partial-access registers suffer
				next_s.wdata = s.rdata;
				next_s.wdata[bit_num] = s.opcode[bbc_pkg::BITDIR_SET_BIT];
				next_s.we = 1'b1;
				// Fourth cycle: the write strobe and completion leave on one edge
				next_s.done = 1'b1;
				next_s.pc = s.pc + bbc_pkg::LEN_2;
				next_s.state = bbc_pkg::BBC_FETCH;
			end
			bbc_pkg::BBC_FINISH: begin
				// Last cycle of the instruction when the counter reads one
				if (s.cnt == bbc_pkg::CNT_ONE) begin
					next_s.state = bbc_pkg::BBC_FETCH;
					next_s.done = 1'b1;
					unique case (s.kind)
						// A branch not taken falls through to the next byte
						bbc_pkg::BBC_K_SHORT:
							next_s.pc = short_take ? s.pc + short_disp : s.pc + bbc_pkg::LEN_1;
						bbc_pkg::BBC_K_BITTEST: begin
							// Sense bit set: branch on one; clear: branch on zero
							if (s.c == s.opcode[bbc_pkg::TEST_SEL_BIT]) begin
								next_s.pc = s.pc + long_disp;
							end else begin
								next_s.pc = s.pc + bbc_pkg::LEN_3;
							end
						end
						// Bit set and clear normally end in the write cycle already
						bbc_pkg::BBC_K_BITDIR: next_s.pc = s.pc + bbc_pkg::LEN_2;
						// Jump and call leave both flags alone
						bbc_pkg::BBC_K_JUMP: next_s.pc = s.target;
						bbc_pkg::BBC_K_CALL: begin
							st_push = 1'b1;
							next_s.pc = s.target;
						end
						bbc_pkg::BBC_K_CTRL: begin
							next_s.pc = s.pc + bbc_pkg::LEN_1;
							if (s.opcode == bbc_pkg::OP_SUB_RETURN
									|| s.opcode == bbc_pkg::OP_INT_RETURN) begin
								st_pop = 1'b1;
								next_s.pc = st_top;
							end else if (s.opcode == bbc_pkg::OP_WAIT) begin
								next_s.waiting = 1'b1;
							end else if (s.opcode == bbc_pkg::OP_STOP) begin
								// Watchdog cannot run with the oscillator stopped
								next_s.waiting = watchdog_option;
								next_s.stopped = !watchdog_option;
							end
						end
						default: next_s.pc = s.pc + bbc_pkg::LEN_1;
					endcase
				end
			end
		endcase
	end
	// State register. Reset parks the sequencer in fetch at address zero with
	// both flags clear and no low-power mode, so the first edge after release
	// already fetches.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{state: bbc_pkg::BBC_FETCH, kind: bbc_pkg::BBC_K_OTHER, pc: bbc_pkg::PC_RESET,
				default: '0};
		end else begin
			s <= next_s;
		end
	end
	// Registered outputs; taken straight from the state register so that
	// they never glitch while the next state is being worked out
	assign pc = s.pc;
	assign flag_c = s.c;
	assign flag_z = s.z;
	assign wait_mode = s.waiting;
	assign stop_mode = s.stopped;
	assign illegal_op = s.illegal;
	assign instr_done = s.done;
	assign data_wdata = s.wdata;
	assign data_we = s.we;
endmodule // bbc_core
`default_nettype wire

// ---- testbench/bbc_core_properties.sv ----
// Port-level timing checks for bbc_core.
// Assumes a bind from the bench top file.
`timescale 1ns/1ns
`default_nettype none
module bbc_core_props (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic watchdog_option,
	input wire logic wake_event,
	input wire logic [11:0] prog_addr,
	input wire logic data_we,
	input wire logic [11:0] pc,
	input wire logic flag_z,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic instr_done
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Strobes last one cycle and the write lands with completion
	a_done_pulse: assert property (instr_done |=> !instr_done)
		else $error("done wider than one cycle");
	a_we_pulse: assert property (data_we |=> !data_we)
		else $error("write strobe too wide");
	a_we_with_done: assert property (data_we |-> instr_done)
		else $error("write outside last cycle");
	// Counter moves only when an instruction ends
	a_pc_steady: assert property (!instr_done |-> $stable(pc))
		else $error("pc moved mid-instruction");
	a_fetch_addr: assert property (instr_done |-> prog_addr == pc)
		else $error("fetch not at pc");
	a_z_kept: assert property (!flag_z)
		else $error("zero flag altered");
	// Low-power modes
	a_wait_idle: assert property (wait_mode |=> !instr_done)
		else $error("instruction ended while waiting");
	a_wake_clears: assert property (wait_mode && wake_event |=> !wait_mode)
		else $error("wake did not leave wait");
	a_stop_option: assert property (stop_mode |-> !watchdog_option)
		else $error("stop taken under watchdog");
	a_mode_excl: assert property (!(wait_mode && stop_mode))
		else $error("wait and stop together");
	// Longest instruction is five cycles
	a_next_bound: assert property (instr_done |=> ##[0:4] (instr_done || wait_mode || stop_mode))
		else $error("next instruction overdue");
	c_write: cover property (data_we);
	c_wait: cover property ($rose(wait_mode));
	c_stop: cover property ($rose(stop_mode));
endmodule // bbc_core_props
`default_nettype wire

// ---- testbench/bbc_mem.sv ----
// Program memory and data space facing bbc_core.
// Assumes the bench fills both arrays before use.
`timescale 1ns/1ns
`default_nettype none
module bbc_mem (
	input wire logic clk_sys,
	input wire logic [11:0] prog_addr,
	output logic [7:0] prog_data,
	input wire logic [7:0] data_addr,
	output logic [7:0] data_rdata,
	input wire logic [7:0] data_wdata,
	input wire logic data_we
);
	logic [7:0] prog [0:4095];
	logic [7:0] dmem [0:255];
	// Same-cycle reads, as the core expects
	assign prog_data = prog[prog_addr];
	assign data_rdata = dmem[data_addr];
	// Plain RAM only, no port registers here
	always @(posedge clk_sys) begin
		if (data_we) begin
			dmem[data_addr] <= data_wdata;
		end
	end
endmodule // bbc_mem
`default_nettype wire

// ---- testbench/test_branch_bit_control_decode.sv ----
// Bench for bbc_core: writes each instruction just before it runs.
// Assumes bbc_mem answers reads in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module test_branch_bit_control_decode;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic watchdog_option = 1'h0;
	logic wake_event = 1'h0;
	logic [7:0] prog_data, data_rdata, data_addr, data_wdata, op, b2, b3, eb;
	logic [11:0] prog_addr, pc, epc, npc;
	logic data_we, flag_c, flag_z, wait_mode, stop_mode, illegal_op, instr_done, ec, tk;
	logic [2:0] bn;
	logic [11:0] stk [$];
	int bad_count = 0;
	int n_checks = 0;
	int k, gap, first;
	always #50 clk_sys = ~clk_sys;
	bbc_core i_bbc_core (.clk_sys(clk_sys), .rst_n(rst_n),
		.watchdog_option(watchdog_option), .wake_event(wake_event),
		.prog_data(prog_data), .prog_addr(prog_addr), .data_rdata(data_rdata),
		.data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we), .pc(pc),
		.flag_c(flag_c), .flag_z(flag_z), .wait_mode(wait_mode), .stop_mode(stop_mode),
		.illegal_op(illegal_op), .instr_done(instr_done));
	bbc_mem i_bbc_mem (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_data(prog_data),
		.data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata),
		.data_we(data_we));
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	function automatic logic [2:0] rev(input logic [2:0] b);
		return {b[0], b[1], b[2]};
	endfunction
	// Model one instruction, place it at the model pc, await its end
	task automatic step(input int kd);
		bn = 3'($urandom);
		b2 = 8'($urandom);
		b3 = 8'($urandom);
		op = 8'h04;
		npc = epc + 12'h001;
		gap = 2;
		if (kd == 9 && stk.size() > 4) kd = 8;
		if ((kd == 10 || kd == 11) && stk.size() == 0) kd = 9;
		if (kd < 4) begin
			op = {5'($urandom), 3'(kd * 2)};
			op[3] = op[3] | (kd == 2); // Keeps clear of the NOP slot
			tk = kd == 0 ? 1'h1 : kd == 1 ? !ec : kd == 3 ? ec : 1'h0;
			if (tk) npc = epc + {{7{op[7]}}, op[7:3]} + 12'h001;
		end else if (kd < 6) begin
			op = {rev(bn), kd == 5, 4'h3};
			tk = i_bbc_mem.dmem[b2][bn];
			npc = epc + (tk == op[4] ? 12'h002 + {{4{b3[7]}}, b3} : 12'h003);
			ec = tk;
			gap = 5;
		end else if (kd < 8) begin
			op = {rev(bn), kd == 6, 4'hB};
			eb = i_bbc_mem.dmem[b2];
			eb[bn] = op[4];
			npc = epc + 12'h002;
			gap = 4;
		end else if (kd < 10) begin
			op = {4'($urandom), kd == 8 ? 4'h9 : 4'h1};
			if (kd == 9) stk.push_back(epc + 12'h002);
			npc = {op[7:4], b2};
			gap = 4;
		end else if (kd < 12) begin
			op = kd == 10 ? 8'hCD : 8'h4D;
			npc = stk.pop_back();
		end else if (kd == 12) begin
			op = b2[0] ? 8'hED : 8'h6D;
			watchdog_option = b3[0];
		end else if (kd == 14) begin
			// Opcode of another group: flagged and stepped over
			op = 8'h07;
		end
		i_bbc_mem.prog[epc] = op;
		i_bbc_mem.prog[epc + 12'h001] = b2;
		i_bbc_mem.prog[epc + 12'h002] = b3;
		rst_n = 1'h1;
		k = 0;
		do begin
			@(posedge clk_sys);
			@(negedge clk_sys);
			k++;
		end while (instr_done !== 1'h1 && k < 20);
		if (k >= 20) begin
			bad_count++;
			stop_test();
		end
		if (!first) check(12'(k), 12'(gap));
		check(pc, npc);
		check(flag_c, ec);
		check(flag_z, 1'h0);
		check(illegal_op, kd == 14);
		if (kd == 6 || kd == 7) begin
			check(data_we, 1'h1);
			check(data_addr, b2);
			check(data_wdata, eb);
			i_bbc_mem.dmem[b2] = eb;
		end
		first = 0;
		epc = npc;
		// Sleep, then wake the core one cycle later
		if (kd == 12) begin
			@(negedge clk_sys);
			check(wait_mode, op[7] | watchdog_option);
			check(stop_mode, !op[7] & !watchdog_option);
			wake_event = 1'h1;
			@(negedge clk_sys);
			wake_event = 1'h0;
			check(wait_mode | stop_mode, 1'h0);
			first = 1;
		end
	endtask
	task automatic do_reset();
		@(negedge clk_sys);
		rst_n = 1'h0;
		repeat (3) @(negedge clk_sys);
		epc = 12'h000;
		ec = 1'h0;
		first = 1;
		stk.delete();
	endtask
	// Every kind in order except interrupt return, which runs as a call there (empty stack), then random kinds; reset again mid-run
	initial begin
		void'($urandom(32'h1fcb5706));
		for (int i = 0; i < 256; i++) begin
			i_bbc_mem.dmem[i] = 8'($urandom);
		end
		for (int r = 0; r < 2; r++) begin
			do_reset();
			for (int i = 0; i < 300; i++) begin
				step(i < 15 ? i : $urandom_range(0, 14));
			end
		end
		stop_test();
	end
endmodule // test_branch_bit_control_decode
bind bbc_core bbc_core_props i_bbc_core_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.watchdog_option(watchdog_option), .wake_event(wake_event), .prog_addr(prog_addr),
	.data_we(data_we), .pc(pc), .flag_z(flag_z), .wait_mode(wait_mode),
	.stop_mode(stop_mode), .instr_done(instr_done));
`default_nettype wire
